// file: hdl/dialer_defines.svh
// Purpose: timing counts and constants of the pulse/tone dialer control
// Assumes: i_clk at 125 MHz stands in for the crystal reference
// Notes: tick, scan and pacifier half-period times in microseconds, others in ms; cycle counts derived from the clock rate
// Functional notes
// - all timing comes from one reference clock, nominally 3.579545 MHz crystal
// - tone symbol is one row plus one column frequency
// - 500 Hz feedback tone after accepted key, ends by 30 ms or release
// - pulse mode: every key beeps; tone mode: only function keys beep
// - mute is open drain, released when idle, pulled low when muting
// - tone mode: mute on at key press until sequence finished
// - pulse mode: mute during each digit, off in interdigit gaps
// - flash: mute asserted 40 ms before line break
// - hook input high on-hook; any transition reinitialises and restores mode
// - flash gives a single 560 ms line-break pulse
// - keypad pulled high on-hook; off-hook rows and columns scanned alternately
// - key valid after 32 ms debounce is stored; signalling starts 40 ms after closure (code starts it right after the debounce accept)
// - redial buffer has 28 entries and wraps over earliest ones
// - redial key replays the stored buffer
// - pause entry stored, inserts a 1.15 to 2.50 s wait when dialled
// - function key waits: pause pulse 1.84/2.50, tone 1.15/1.20, mode 1.15/1.85
// - first entry when all earlier input sent; auto in redial or while busy (code picks auto only in redial or with later entries still queued)
// - after flash, keys ignored until 560 ms break is signalled
// - first non-flash key after flash starts a new number in the buffer
// - stored flashes replay as delays without break pulses
// - tone redial keeps mute asserted through flash delays
// - star in pulse mode switches to tone one way; later stars send star tone
// - manual tone: presses up to 32 ms ignored, min 75 ms tone, else press minus debounce
// - tone redial: 75 ms tone, 50 ms gaps
// - mode select high means tone, low means pulse, at reset and off-hook
// - pulse digits at 10 pps: 60 ms break, 40 ms make, 740 ms gap
`ifndef DIALER_DEFINES_SVH
`define DIALER_DEFINES_SVH
`define CLK_MHZ          125
`define US2CYC(us)       ((us) * `CLK_MHZ)
`define XTAL_HZ          3579545
`define ROW_FREQ_DHZ     {16'd6991, 16'd7662, 16'd8474, 16'd9480}
`define COL_FREQ_DHZ     {16'd12159, 16'd13317, 16'd14719}
`define T_TICK_US        1000
`define TICK_CYC         (`US2CYC(`T_TICK_US))
`define T_SCAN_US        2000
`define SCAN_CYC         (`US2CYC(`T_SCAN_US))
`define T_PACI_HALF_US   1000
`define PACI_HALF_CYC    (`US2CYC(`T_PACI_HALF_US))
`define T_DEBOUNCE_MS    32
`define T_PACI_MS        30
`define T_PRESIG_MS      40
`define T_MUTE_LEAD_MS   40
`define T_FLASH_MS       560
`define T_TONE_MS        75
`define T_GAP_MS         50
`define T_BREAK_MS       60
`define T_MAKE_MS        40
`define T_IDP_MS         740
`define T_PAUSE_MS       1100
`define T_PAUSE_PF_MS    1840
`define T_PAUSE_PA_MS    2500
`define T_PAUSE_TF_MS    1150
`define T_PAUSE_TA_MS    1200
`define T_SOFT_F_MS      1150
`define T_SOFT_A_MS      1850
`define BUF_DEPTH        28
`define KEY_STAR         4'h0A
`define KEY_HASH         4'h0B
`define KEY_FLASH        4'h0C
`define KEY_SOFT         4'h0D
`define KEY_PAUSE        4'h0E
`define KEY_REDIAL       4'h0F
`endif

// file: hdl/dialer_pkg.sv
// Purpose: shared types of the dialer control
// Assumes: nothing
// Notes: constants live in dialer_defines.svh
package dialer_pkg;
  typedef logic [3:0] key_t;
  typedef struct packed {
    logic [3:0] row;
    logic [2:0] col;
  } tone_pair_s;
  typedef struct packed {
    logic valid;
    key_t code;
  } key_ev_s;
  typedef enum logic [2:0] {S_IDLE, S_LEAD, S_TONE, S_GAP, S_BREAK, S_MAKE, S_WAIT,
                            S_FLASH} seq_e;
endpackage : dialer_pkg

// file: hdl/key_scanner.sv
// Purpose: alternating row/column keypad scan with 32 ms debounce
// Assumes: keypad inputs synchronous, low when a key connects
// Notes: emits accept pulse, holds key code and press status
`include "dialer_defines.svh"
`timescale 1ns/100ps
module key_scanner (
  input  wire logic            i_clk,
  input  wire logic            i_rst,
  input  wire logic            i_on_hook,
  input  wire logic            i_ms_tick,
  input  wire logic [3:0]      i_row_in,
  input  wire logic [3:0]      i_col_in,
  output logic      [3:0]      o_row_drv,
  output logic      [3:0]      o_col_drv,
  output logic                 o_closed,
  output logic                 o_accept,
  output dialer_pkg::key_ev_s  o_key
);
  logic        phase_r;
  logic [1:0]  scan_cnt_r;
  logic [3:0]  row_seen_r;
  logic [3:0]  col_seen_r;
  logic [5:0]  db_cnt_r;
  logic        done_r;

  function automatic logic one_hot4(input logic [3:0] v);
    one_hot4 = (v != 4'h0) && ((v & (v - 4'h1)) == 4'h0);
  endfunction : one_hot4

  function automatic dialer_pkg::key_t encode(input logic [3:0] r, input logic [3:0] c);
    logic [1:0] ri;
    logic [1:0] ci;
    ri = r[0] ? 2'd0 : r[1] ? 2'd1 : r[2] ? 2'd2 : 2'd3;
    ci = c[0] ? 2'd0 : c[1] ? 2'd1 : c[2] ? 2'd2 : 2'd3;
    if (ci == 2'd3) begin
      encode = (ri == 2'd0) ? `KEY_FLASH : (ri == 2'd1) ? `KEY_SOFT :
               (ri == 2'd2) ? `KEY_PAUSE : `KEY_REDIAL;
    end else if (ri == 2'd3) begin
      encode = (ci == 2'd0) ? `KEY_STAR : (ci == 2'd1) ? 4'h0 : `KEY_HASH;
    end else begin
      encode = 4'({2'b00, ri} * 4'd3 + {2'b00, ci} + 4'd1);
    end
  endfunction : encode

  // on-hook all lines high; off-hook one group driven high per phase
  always_comb begin
    o_row_drv = (i_on_hook || !phase_r) ? 4'hF : 4'h0;
    o_col_drv = (i_on_hook || phase_r) ? 4'hF : 4'h0;
  end

  always_ff @(posedge i_clk) begin
    if (i_rst || i_on_hook) begin
      phase_r    <= 1'b0;
      scan_cnt_r <= '0;
      row_seen_r <= '0;
      col_seen_r <= '0;
    end else if (i_ms_tick) begin
      // the group driven high this phase is the one a contact pulls low
      if (scan_cnt_r == 2'(`T_SCAN_US / `T_TICK_US - 1)) begin
        scan_cnt_r <= '0;
        phase_r    <= ~phase_r;
        if (phase_r) col_seen_r <= ~i_col_in;
        else row_seen_r <= ~i_row_in;
      end else begin
        scan_cnt_r <= scan_cnt_r + 2'h1;
      end
    end
  end

  assign o_closed = (row_seen_r != 4'h0) && (col_seen_r != 4'h0);

  // debounce: sample again after 32 ms of closure
  always_ff @(posedge i_clk) begin
    if (i_rst || i_on_hook || !o_closed) begin
      db_cnt_r <= '0;
      done_r   <= 1'b0;
      o_accept <= 1'b0;
      o_key    <= '0;
    end else begin
      o_accept <= 1'b0;
      if (i_ms_tick && !done_r) begin
        if (db_cnt_r == 6'(`T_DEBOUNCE_MS - 1)) begin
          done_r <= 1'b1;
          if (one_hot4(row_seen_r) && one_hot4(col_seen_r)) begin
            o_accept   <= 1'b1;
            o_key.valid <= 1'b1;
            o_key.code <= encode(row_seen_r, col_seen_r);
          end
        end else begin
          db_cnt_r <= db_cnt_r + 6'h01;
        end
      end
    end
  end
endmodule : key_scanner

// file: hdl/dialer_ctrl.sv
// Purpose: pulse/tone dialer sequencing, redial memory, mute, break and pacifier
// Assumes: i_clk 125 MHz stands in for the crystal; inputs synchronous
// Notes: tone synthesis itself is outside; o_tone carries the row/column pair
`include "dialer_defines.svh"
`timescale 1ns/100ps
module dialer_ctrl #(
  parameter int TICK_CYCLES = `TICK_CYC
) (
  input  wire logic               i_clk,
  input  wire logic               i_rst,
  input  wire logic               i_hook,
  input  wire logic               i_mode_tone,
  input  wire logic [3:0]         i_row_in,
  input  wire logic [3:0]         i_col_in,
  output logic      [3:0]         o_row_drv,
  output logic      [3:0]         o_col_drv,
  output logic                    o_mute_in,
  output logic                    o_mute_out,
  output logic                    o_mute_oe,
  output logic                    o_break_in,
  output logic                    o_break_out,
  output logic                    o_break_oe,
  output logic                    o_pacifier,
  output logic                    o_tone_on,
  output dialer_pkg::tone_pair_s  o_tone
);
  logic                  tick_r;
  logic [16:0]           tick_cnt_r;
  logic                  hook_r;
  logic                  reinit;
  logic                  closed;
  logic                  accept;
  dialer_pkg::key_ev_s   key;
  dialer_pkg::key_t      mem_r [`BUF_DEPTH];
  logic [4:0]            wr_r;
  logic [4:0]            len_r;
  logic [4:0]            rd_r;
  logic [4:0]            pend_r;
  logic                  redial_r;
  logic                  new_num_r;
  logic                  tone_mode_r;
  dialer_pkg::seq_e      st_r;
  logic [11:0]           tmr_r;
  logic [3:0]            pulses_r;
  dialer_pkg::key_t      cur_r;
  logic                  held_r;
  logic [5:0]            paci_ms_r;
  logic [16:0]           paci_cnt_r;
  logic                  mute_r;
  logic                  brk_r;
  logic                  busy;
  dialer_pkg::key_t      next_key;
  logic                  take;

  assign o_mute_in  = 1'b1;
  assign o_break_in = 1'b1;

  function automatic logic [4:0] wrap_inc(input logic [4:0] v);
    wrap_inc = (v == 5'(`BUF_DEPTH - 1)) ? 5'h00 : v + 5'h01;
  endfunction : wrap_inc

  // keys 1..9,0,*,#: row/column pair by keypad position
  function automatic dialer_pkg::tone_pair_s pair_of(input dialer_pkg::key_t k);
    logic [3:0] idx;
    idx = (k == 4'h0) ? 4'd10 : (k == `KEY_STAR) ? 4'd9 : (k == `KEY_HASH) ? 4'd11 : k - 4'h1;
    pair_of.row = 4'h1 << (idx / 4'd3);
    pair_of.col = 3'(3'h1 << (idx % 4'd3));
  endfunction : pair_of

  // ms tick from the single clock
  // every later time, scan and pacifier included, counts this tick
  always_ff @(posedge i_clk) begin
    if (i_rst || tick_cnt_r == 17'(TICK_CYCLES - 1)) tick_cnt_r <= '0;
    else tick_cnt_r <= tick_cnt_r + 17'h0_0001;
    tick_r <= !i_rst && tick_cnt_r == 17'(TICK_CYCLES - 1);
  end

  always_ff @(posedge i_clk) begin
    hook_r <= i_rst ? 1'b1 : i_hook;
  end
  assign reinit = i_rst || (hook_r != i_hook);

  key_scanner u_scan (
    .i_clk     (i_clk),
    .i_rst     (reinit),
    .i_on_hook (i_hook),
    .i_ms_tick (tick_r),
    .i_row_in  (i_row_in),
    .i_col_in  (i_col_in),
    .o_row_drv (o_row_drv),
    .o_col_drv (o_col_drv),
    .o_closed  (closed),
    .o_accept  (accept),
    .o_key     (key)
  );

  assign busy = (st_r != dialer_pkg::S_IDLE) || (pend_r != 5'h00);
  assign next_key = mem_r[rd_r];
  // a fresh accept goes first so queue count and read index stay in step
  assign take = (st_r == dialer_pkg::S_IDLE) && (pend_r != 5'h00) && !accept;

  // mode register: default from mode pin, one-way switch by star
  always_ff @(posedge i_clk) begin
    if (reinit) tone_mode_r <= i_mode_tone;
    else if (take && next_key == `KEY_SOFT)
      tone_mode_r <= 1'b1;
  end

  // redial memory; flash ignore window, new number after flash
  always_ff @(posedge i_clk) begin
    if (reinit) begin
      wr_r      <= '0;
      len_r     <= '0;
      pend_r    <= '0;
      rd_r      <= '0;
      redial_r  <= 1'b0;
      new_num_r <= 1'b0;
      for (int i = 0; i < `BUF_DEPTH; i++) mem_r[i] <= '0;
    end else begin
      if (accept && !(st_r inside {dialer_pkg::S_LEAD, dialer_pkg::S_FLASH})) begin
        if (key.code == `KEY_REDIAL) begin
          if (!busy && len_r != 5'h00) begin
            rd_r     <= '0;
            pend_r   <= len_r;
            redial_r <= 1'b1;
          end
        end else begin
          logic [3:0] c;
          c = (key.code == `KEY_STAR && !tone_mode_r) ? `KEY_SOFT : key.code;
          if (new_num_r && c != `KEY_FLASH) begin
            mem_r[0]  <= c;
            wr_r      <= 5'h01;
            len_r     <= 5'h01;
            rd_r      <= '0;
            pend_r    <= 5'h01;
            new_num_r <= 1'b0;
          end else begin
            mem_r[wr_r] <= c;
            wr_r        <= wrap_inc(wr_r);
            if (len_r != 5'(`BUF_DEPTH)) len_r <= len_r + 5'h01;
            if (!busy) rd_r <= wr_r;
            pend_r <= busy ? pend_r + 5'h01 : 5'h01;
            if (!busy) redial_r <= 1'b0;
          end
        end
      end
      if (take) begin
        rd_r   <= wrap_inc(rd_r);
        pend_r <= pend_r - 5'h01;
        if (next_key == `KEY_FLASH && !redial_r) new_num_r <= 1'b1;
      end
    end
  end

  // sequencer: tone, pulse, pause, softswitch and flash timing
  always_ff @(posedge i_clk) begin
    if (reinit) begin
      st_r     <= dialer_pkg::S_IDLE;
      tmr_r    <= '0;
      pulses_r <= '0;
      cur_r    <= '0;
      held_r   <= 1'b0;
    end else if (st_r == dialer_pkg::S_IDLE) begin
      if (take) begin
        logic auto;
        auto   = redial_r || pend_r > 5'h01;
        cur_r  <= next_key;
        held_r <= !redial_r;
        tmr_r  <= '0;
        unique case (next_key)
          `KEY_PAUSE: begin
            st_r  <= dialer_pkg::S_WAIT;
            tmr_r <= 12'(tone_mode_r ? (auto ? `T_PAUSE_TA_MS : `T_PAUSE_TF_MS)
                                     : (auto ? `T_PAUSE_PA_MS : `T_PAUSE_PF_MS));
          end
          `KEY_SOFT: begin
            st_r  <= dialer_pkg::S_WAIT;
            tmr_r <= 12'(auto ? `T_SOFT_A_MS : `T_SOFT_F_MS);
          end
          `KEY_FLASH: begin
            // redial replays flash as a delay only
            st_r  <= redial_r ? dialer_pkg::S_WAIT : dialer_pkg::S_LEAD;
            tmr_r <= 12'(redial_r ? `T_FLASH_MS : `T_MUTE_LEAD_MS);
          end
          default: begin
            st_r     <= tone_mode_r ? dialer_pkg::S_TONE : dialer_pkg::S_BREAK;
            tmr_r    <= 12'(tone_mode_r ? `T_TONE_MS : `T_BREAK_MS);
            pulses_r <= (next_key == 4'h0) ? 4'd10 : next_key;
          end
        endcase
      end
    end else if (tick_r) begin
      if (!closed) held_r <= 1'b0;
      if (tmr_r > 12'h001) tmr_r <= tmr_r - 12'h001;
      unique case (st_r)
        dialer_pkg::S_LEAD: if (tmr_r <= 12'h001) begin
          st_r  <= dialer_pkg::S_FLASH;
          tmr_r <= 12'(`T_FLASH_MS);
        end
        dialer_pkg::S_TONE: if (tmr_r <= 12'h001 && !(held_r && closed)) begin
          st_r  <= dialer_pkg::S_GAP;
          tmr_r <= 12'(`T_GAP_MS);
        end
        dialer_pkg::S_BREAK: if (tmr_r <= 12'h001) begin
          st_r     <= dialer_pkg::S_MAKE;
          tmr_r    <= 12'(`T_MAKE_MS);
          pulses_r <= pulses_r - 4'h1;
        end
        dialer_pkg::S_MAKE: if (tmr_r <= 12'h001) begin
          st_r  <= (pulses_r == 4'h0) ? dialer_pkg::S_WAIT : dialer_pkg::S_BREAK;
          tmr_r <= 12'((pulses_r == 4'h0) ? `T_IDP_MS : `T_BREAK_MS);
        end
        default: if (tmr_r <= 12'h001) st_r <= dialer_pkg::S_IDLE;
      endcase
    end
  end

  // mute and break outputs
  always_ff @(posedge i_clk) begin
    if (reinit) begin
      mute_r <= 1'b0;
      brk_r  <= 1'b0;
    end else begin
      brk_r <= (st_r == dialer_pkg::S_FLASH) || (st_r == dialer_pkg::S_BREAK);
      if (tone_mode_r)
        mute_r <= closed || busy;
      else
        mute_r <= st_r inside {dialer_pkg::S_BREAK, dialer_pkg::S_MAKE, dialer_pkg::S_LEAD,
                               dialer_pkg::S_FLASH};
    end
  end
  assign o_mute_out  = 1'b0;
  assign o_mute_oe   = mute_r;
  assign o_break_out = 1'b0;
  assign o_break_oe  = brk_r;

  // tone output pair
  always_ff @(posedge i_clk) begin
    if (reinit) begin
      o_tone_on <= 1'b0;
      o_tone    <= '0;
    end else begin
      o_tone_on <= st_r == dialer_pkg::S_TONE;
      o_tone    <= pair_of(cur_r);
    end
  end

  // pacifier tone: 500 Hz for up to 30 ms after accept
  always_ff @(posedge i_clk) begin
    if (reinit || !closed) begin
      paci_ms_r  <= '0;
      paci_cnt_r <= '0;
      o_pacifier <= 1'b0;
    end else if (accept && (!tone_mode_r || key.code >= `KEY_FLASH)) begin
      paci_ms_r  <= 6'(`T_PACI_MS);
      paci_cnt_r <= '0;
    end else if (paci_ms_r != 6'h00) begin
      if (tick_r) begin
        paci_ms_r <= paci_ms_r - 6'h01;
        if (paci_cnt_r == 17'(`T_PACI_HALF_US / `T_TICK_US - 1)) begin
          paci_cnt_r <= '0;
          o_pacifier <= ~o_pacifier;
        end else begin
          paci_cnt_r <= paci_cnt_r + 17'h0_0001;
        end
      end
    end else begin
      o_pacifier <= 1'b0;
    end
  end

  flash_break_a: assert property (@(posedge i_clk) disable iff (reinit)
    st_r == dialer_pkg::S_FLASH |=> o_break_oe)
    else $error("break not driven during flash");
  lead_mute_a: assert property (@(posedge i_clk) disable iff (reinit)
    st_r == dialer_pkg::S_LEAD |=> o_mute_oe && !o_break_oe)
    else $error("mute lead before break wrong");
  pulse_mute_a: assert property (@(posedge i_clk) disable iff (reinit)
    !tone_mode_r && st_r == dialer_pkg::S_IDLE && !$past(busy) |=> !o_mute_oe)
    else $error("mute in pulse gap");
  tone_mute_a: assert property (@(posedge i_clk) disable iff (reinit)
    tone_mode_r && busy |=> o_mute_oe)
    else $error("tone mute dropped while busy");
  paci_off_a: assert property (@(posedge i_clk) disable iff (reinit)
    !closed |=> !o_pacifier)
    else $error("pacifier after release");
  tone_hold_a: assert property (@(posedge i_clk) disable iff (reinit)
    st_r == dialer_pkg::S_TONE |=> o_tone_on)
    else $error("tone output missing");
  redial_nobreak_a: assert property (@(posedge i_clk) disable iff (reinit)
    redial_r && take && next_key == `KEY_FLASH
    |=> st_r == dialer_pkg::S_WAIT)
    else $error("redial flash broke line");
  wrap_a: assert property (@(posedge i_clk) disable iff (reinit)
    len_r <= 5'(`BUF_DEPTH))
    else $error("buffer length overrun");
  flash_c: cover property (@(posedge i_clk) st_r == dialer_pkg::S_FLASH);
  pulse_c: cover property (@(posedge i_clk) st_r == dialer_pkg::S_MAKE);
  redial_c: cover property (@(posedge i_clk) redial_r && st_r == dialer_pkg::S_TONE);
endmodule : dialer_ctrl

// file: testbench/keypad_line_model.sv
// Purpose: keypad contact and line pull-up model facing the dialer
// Assumes: one key at a time, a contact ties its row and column lines together
// Notes: open-drain lines idle high through the external pull-up
`timescale 1ns/100ps
module keypad_line_model (
  input  wire logic       i_press,
  input  wire logic [1:0] i_row_sel,
  input  wire logic [1:0] i_col_sel,
  input  wire logic [3:0] i_row_drv,
  input  wire logic [3:0] i_col_drv,
  input  wire logic       i_mute_oe,
  input  wire logic       i_break_oe,
  output logic      [3:0] o_row_in,
  output logic      [3:0] o_col_in,
  output logic            o_mute_n,
  output logic            o_break_n
);
  // a closed contact is a wired-and of the two lines it joins
  always_comb begin
    o_row_in = i_row_drv;
    o_col_in = i_col_drv;
    if (i_press) begin
      o_row_in[i_row_sel] = i_row_drv[i_row_sel] & i_col_drv[i_col_sel];
      o_col_in[i_col_sel] = i_row_drv[i_row_sel] & i_col_drv[i_col_sel];
    end
  end
  assign o_mute_n  = i_mute_oe ? 1'b0 : 1'b1;
  assign o_break_n = i_break_oe ? 1'b0 : 1'b1;
endmodule : keypad_line_model

// file: testbench/test_dialer_ctrl.sv
// Purpose: self-checking bench of the dialer control
// Assumes: ms tick shortened to 20 cycles through the divider parameter
// Notes: break, tone and pacifier widths are measured by a monitor
`timescale 1ns/100ps
module test_dialer_ctrl;
  localparam int MS = 20;
  logic i_clk, i_rst, i_hook, i_mode_tone, press;
  logic [1:0] row_sel, col_sel;
  logic [3:0] i_row_in, o_row_drv;
  logic [3:0] i_col_in, o_col_drv;
  logic o_mute_in, o_mute_out, o_mute_oe, o_break_in, o_break_out, o_break_oe;
  logic o_pacifier, o_tone_on, mute_n, break_n;
  dialer_pkg::tone_pair_s o_tone;
  int fails, comparisons, brk_rises, pac_rises, ton_rises, brk_unmuted;
  longint brk_len, brk_last, ton_len, ton_last, pac_len, pac_first;
  bit brk_q, ton_q, pac_q;

  dialer_ctrl #(.TICK_CYCLES(MS)) uut (.i_clk(i_clk), .i_rst(i_rst), .i_hook(i_hook),
    .i_mode_tone(i_mode_tone), .i_row_in(i_row_in), .i_col_in(i_col_in),
    .o_row_drv(o_row_drv), .o_col_drv(o_col_drv),
    .o_mute_in(o_mute_in), .o_mute_out(o_mute_out), .o_mute_oe(o_mute_oe),
    .o_break_in(o_break_in), .o_break_out(o_break_out), .o_break_oe(o_break_oe),
    .o_pacifier(o_pacifier), .o_tone_on(o_tone_on), .o_tone(o_tone));
  keypad_line_model partner (.i_press(press), .i_row_sel(row_sel), .i_col_sel(col_sel),
    .i_row_drv(o_row_drv), .i_col_drv(o_col_drv), .i_mute_oe(o_mute_oe),
    .i_break_oe(o_break_oe), .o_row_in(i_row_in), .o_col_in(i_col_in),
    .o_mute_n(mute_n), .o_break_n(break_n));

  initial begin
    i_clk = 1'b0;
    forever #4 i_clk = ~i_clk;
  end

  // width and edge monitor on pre-edge values
  always @(posedge i_clk) begin
    if (o_break_oe === 1'b1) begin
      if (!brk_q) begin
        brk_rises++;
        brk_len = 0;
        if (o_mute_oe !== 1'b1) brk_unmuted++;
      end
      brk_len++;
    end else if (brk_q) brk_last = brk_len;
    brk_q = (o_break_oe === 1'b1);
    if (o_tone_on === 1'b1) begin
      if (!ton_q) begin
        ton_rises++;
        ton_len = 0;
      end
      ton_len++;
    end else if (ton_q) ton_last = ton_len;
    ton_q = (o_tone_on === 1'b1);
    if (o_pacifier === 1'b1) begin
      if (!pac_q) begin
        pac_rises++;
        pac_len = 0;
      end
      pac_len++;
    end else if (pac_q && pac_rises == 1) pac_first = pac_len;
    pac_q = (o_pacifier === 1'b1);
  end

  task automatic clear_mon();
    brk_rises = 0; pac_rises = 0; ton_rises = 0; brk_unmuted = 0;
    brk_last = 0; ton_last = 0; pac_first = 0;
  endtask : clear_mon

  task automatic fail_msg(input string msg);
    fails++;
    $display("[FAIL] t=%0t %s", $time, msg);
  endtask : fail_msg

  task automatic check_vec(input logic [7:0] got, input logic [7:0] exp, input string what);
    comparisons++;
    if (got !== exp) fail_msg($sformatf("%s got %h exp %h", what, got, exp));
  endtask : check_vec

  task automatic check_range(input longint got, input longint lo, input longint hi,
                             input string what);
    comparisons++;
    if (got < lo || got > hi) fail_msg($sformatf("%s got %0d not in %0d..%0d", what, got, lo, hi));
  endtask : check_range

  function automatic logic pick(input int sel);
    case (sel)
      0:       return o_mute_oe;
      1:       return o_tone_on;
      2:       return o_pacifier;
      default: return o_break_oe;
    endcase
  endfunction : pick

  task automatic wait_sig(input int sel, input logic lvl, input int max_ms);
    longint n;
    n = 0;
    while (pick(sel) !== lvl && n < longint'(max_ms) * MS) begin
      @(posedge i_clk);
      #1;
      n++;
    end
    // one more edge lets the width monitor record the change
    @(posedge i_clk);
    #1;
    comparisons++;
    if (pick(sel) !== lvl) fail_msg($sformatf("signal %0d did not reach %b", sel, lvl));
  endtask : wait_sig

  task automatic wait_ms(input int n);
    repeat (n) repeat (MS) @(posedge i_clk);
    #1;
  endtask : wait_ms

  task automatic key(input logic down, input logic [1:0] r, input logic [1:0] c);
    @(posedge i_clk);
    #1;
    row_sel = r;
    col_sel = c;
    press = down;
  endtask : key

  task automatic go_off_hook(input logic tone);
    @(posedge i_clk);
    #1;
    i_hook = 1'b1;
    i_mode_tone = tone;
    wait_ms(2);
    @(posedge i_clk);
    #1;
    i_hook = 1'b0;
    wait_ms(5);
    clear_mon();
  endtask : go_off_hook

  task automatic test_reset();
    check_vec({4'h0, o_mute_oe, o_break_oe, o_tone_on, o_pacifier}, 8'h00, "idle outputs");
    check_vec({7'h00, o_mute_out}, 8'h00, "mute pulls low only");
    check_vec({7'h00, mute_n}, 8'h01, "mute line released");
    check_vec({o_row_drv, o_col_drv}, 8'hFF, "on-hook keypad high");
    $display("test_reset done");
  endtask : test_reset

  task automatic test_pulse_digit();
    go_off_hook(1'b0);
    key(1'b1, 2'd0, 2'd1);
    wait_sig(2, 1'b1, 60);
    wait_sig(3, 1'b1, 100);
    wait_ms(5);
    key(1'b0, 2'd0, 2'd0);
    wait_sig(0, 1'b0, 1500);
    check_range(brk_rises, 2, 2, "breaks for digit two");
    check_range(brk_last, 59 * MS, 61 * MS, "break width");
    check_range(brk_unmuted, 0, 0, "break outside mute");
    check_range(pac_first, MS - 2, MS + 2, "pacifier half period");
    wait_ms(100);
    check_vec({6'h00, o_mute_oe, o_break_oe}, 8'h00, "interdigit gap quiet");
    $display("test_pulse_digit done");
  endtask : test_pulse_digit

  task automatic test_tone_digit();
    go_off_hook(1'b1);
    key(1'b1, 2'd1, 2'd1);
    wait_ms(50);
    key(1'b0, 2'd0, 2'd0);
    wait_sig(1, 1'b1, 100);
    check_vec({7'h00, o_mute_oe}, 8'h01, "mute with tone");
    check_vec({1'b0, o_tone}, 8'h12, "tone pair row two col two");
    wait_sig(1, 1'b0, 200);
    check_range(ton_last, 74 * MS, 76 * MS, "short press tone width");
    check_range(pac_rises, 0, 0, "no pacifier for digit");
    check_range(brk_rises, 0, 0, "no breaks in tone mode");
    wait_sig(0, 1'b0, 200);
    $display("test_tone_digit done");
  endtask : test_tone_digit

  task automatic test_hook_abort();
    go_off_hook(1'b0);
    key(1'b1, 2'd2, 2'd2);
    wait_sig(3, 1'b1, 100);
    key(1'b0, 2'd0, 2'd0);
    i_hook = 1'b1;
    repeat (3) @(posedge i_clk);
    #1;
    check_vec({6'h00, o_mute_oe, o_break_oe}, 8'h00, "hook aborts dialing");
    check_vec({o_row_drv, o_col_drv}, 8'hFF, "keypad high on-hook");
    wait_ms(200);
    check_range(brk_rises, 1, 1, "no breaks after abort");
    $display("test_hook_abort done");
  endtask : test_hook_abort

  task automatic test_flash_redial();
    go_off_hook(1'b0);
    key(1'b1, 2'd0, 2'd3);
    wait_sig(0, 1'b1, 60);
    wait_ms(30);
    check_vec({7'h00, o_break_oe}, 8'h00, "break waits for mute lead");
    wait_sig(3, 1'b1, 20);
    key(1'b0, 2'd0, 2'd0);
    wait_sig(3, 1'b0, 600);
    check_range(brk_last, 559 * MS, 561 * MS, "flash break width");
    check_range(brk_unmuted, 0, 0, "flash break outside mute");
    check_range(pac_rises, 1, 15, "pacifier for flash");
    key(1'b1, 2'd0, 2'd0);
    wait_sig(3, 1'b1, 60);
    key(1'b0, 2'd0, 2'd0);
    wait_sig(0, 1'b0, 300);
    wait_ms(740);
    clear_mon();
    key(1'b1, 2'd3, 2'd3);
    wait_sig(3, 1'b1, 60);
    key(1'b0, 2'd0, 2'd0);
    wait_sig(0, 1'b0, 300);
    check_range(brk_rises, 1, 1, "redial sends only the new number");
    $display("test_flash_redial done");
  endtask : test_flash_redial

  task automatic summarize();
    $display("comparisons=%0d fails=%0d", comparisons, fails);
    if (fails == 0 && comparisons > 0) begin
      $display("ALL CHECKS OK");
    end else begin
      $display("CHECKS NOT OK");
    end
    $finish;
  endtask : summarize

  initial begin
    wait_ms(4000);
    fail_msg("watchdog expired");
    summarize();
  end

  initial begin
    i_rst = 1'b1;
    i_hook = 1'b1;
    i_mode_tone = 1'b0;
    press = 1'b0;
    row_sel = 2'd0;
    col_sel = 2'd0;
    fails = 0;
    comparisons = 0;
    clear_mon();
    repeat (6) @(posedge i_clk);
    #1;
    i_rst = 1'b0;
    @(posedge i_clk);
    #1;
    test_reset();
    test_pulse_digit();
    test_tone_digit();
    test_hook_abort();
    test_flash_redial();
    summarize();
  end
endmodule : test_dialer_ctrl
